// ===== dv/apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  // Clock
  input wire clk_sys,
  // APB master
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h0,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'hf,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Set when the slave never answers
  output logic hang = 1'b0
);
  // One transfer; request held until pready is seen at an edge or 16 access edges pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!pready && n < 16);
    rd = prdata;
    err = pslverr;
    hang <= (n >= 16);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines do not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host
`default_nettype wire

// ===== dv/glb_regs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module glb_regs_chk (
  // Clock, reset and APB
  input wire clk_sys,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Line side
  input wire [13:0] transmit_line_clock_present,
  input wire [13:0] tx_data,
  input wire [13:0] line_driver_outputs,
  input wire [13:0] all_ones_transmit,
  input wire [15:0] synth_freq_khz,
  input wire synth_retune
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Answer lasts one cycle so back-to-back transfers stay distinct
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held too long");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr outside access");
  property p_rd_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits set");
  property p_hi_top; pready && !pwrite && paddr == 12'h3ac |-> prdata[7:6] == 2'b00; endproperty
  a_hi_top: assert property (p_hi_top)
    else $error("high summary top bits set");
  // Missing clock: line shows the pattern, which equals the all-ones flag
  property p_line;
    $past(arst_n) |-> (line_driver_outputs & ~$past(transmit_line_clock_present))
      == all_ones_transmit;
  endproperty
  a_line: assert property (p_line)
    else $error("missing clock pattern wrong");
  property p_tx_pass;
    $past(arst_n) |-> ((line_driver_outputs ^ $past(tx_data))
      & $past(transmit_line_clock_present)) == 14'h0;
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("data not passed with clock");
  property p_freq;
    synth_freq_khz inside {16'd2048, 16'd1544, 16'd4096, 16'd3088,
      16'd8192, 16'd6176, 16'd16384, 16'd12352};
  endproperty
  a_freq: assert property (p_freq)
    else $error("illegal synthesizer frequency");
  property p_retune;
    synth_retune |-> $past(psel && penable && pready && pwrite, 2) && !$past(synth_retune);
  endproperty
  a_retune: assert property (p_retune)
    else $error("retune without write");
endmodule // glb_regs_chk
bind global_clock_and_irq_regs glb_regs_chk u_chk (.clk_sys, .arst_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .transmit_line_clock_present, .tx_data,
  .line_driver_outputs, .all_ones_transmit, .synth_freq_khz, .synth_retune);
`default_nettype wire

// ===== dv/global_clock_and_irq_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module global_clock_and_irq_regs_tb;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, hang, synth_retune, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [13:0] chirq, clkp, txd, lout, aot;
  logic [15:0] fkhz;
  int err_total = 0;
  int checked = 0;
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  apb_host u_host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .hang);
  global_clock_and_irq_regs u_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .channel_irq_in(chirq),
    .transmit_line_clock_present(clkp), .tx_data(txd), .line_driver_outputs(lout),
    .all_ones_transmit(aot), .synth_freq_khz(fkhz), .synth_retune, .irq);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, err);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    chk(nm, e, rd);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A hung transfer ends the run
  always @(posedge hang)
  begin
    err_total++;
    stop_test;
  end
  function logic [15:0] khz(input logic [3:0] c);
    case (c)
      4'h1, 4'hf: khz = 16'd1544;
      4'h8: khz = 16'd4096;
      4'h9: khz = 16'd3088;
      4'ha: khz = 16'd8192;
      4'hb: khz = 16'd6176;
      4'hc: khz = 16'd16384;
      4'hd: khz = 16'd12352;
      default: khz = 16'd2048;
    endcase
  endfunction
  task t_reset;
    rdc("ref_sel", 12'h3a4, 32'h0);
    rdc("sum_lo", 12'h3a8, 32'h0);
    rdc("sum_hi", 12'h3ac, 32'h0);
    rdc("unmapped", 12'h3b0, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("t_reset done");
  endtask
  // Every code, pattern bit left at zero so no write changes both fields
  task t_freq;
    for (int c = 0; c < 16; c++)
    begin
      wr(12'h3a4, c);
      repeat (3) @(posedge clk_sys);
      chk("freq", {16'h0, khz(4'(c))}, {16'h0, fkhz});
    end
    $display("t_freq done");
  endtask
  task t_pattern;
    wr(12'h3a4, 32'hef);
    rdc("ref_sel", 12'h3a4, 32'hef);
    wr(12'h3a4, 32'hff);
    clkp <= 14'h00ff;
    txd <= 14'h0f0f;
    repeat (2) @(posedge clk_sys);
    chk("line1", 32'h3f0f, {18'h0, lout});
    chk("aos1", 32'h3f00, {18'h0, aot});
    wr(12'h3a4, 32'hef);
    repeat (2) @(posedge clk_sys);
    chk("line0", 32'h000f, {18'h0, lout});
    chk("aos0", 32'h0, {18'h0, aot});
    clkp <= 14'h3fff;
    $display("t_pattern done");
  endtask
  task t_summary;
    chirq <= 14'h2a5a;
    @(posedge clk_sys);
    chirq <= 14'h0;
    rdc("sum_lo", 12'h3a8, 32'h5a);
    rdc("sum_hi", 12'h3ac, 32'h2a);
    rdc("sum_lo2", 12'h3a8, 32'h0);
    // Event lands on the completion edge of a read and must survive it
    fork
      rdc("sum_lo3", 12'h3a8, 32'h0);
      begin
        repeat (3) @(posedge clk_sys);
        chirq <= 14'h1;
        @(posedge clk_sys);
        chirq <= 14'h0;
      end
    join
    rdc("sum_lo4", 12'h3a8, 32'h1);
    $display("t_summary done");
  endtask
  task t_irq;
    rdc("status", 12'h3e0, 32'h3);
    wr(12'h3e4, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(12'h3e0, 32'h7);
    repeat (3) @(posedge clk_sys);
    chk("irq_off", 32'h0, {31'h0, irq});
    rdc("status0", 12'h3e0, 32'h0);
    $display("t_irq done");
  endtask
  // Lane 0 strobe low must leave the select untouched; then one write moves
  // pattern and code together so the conflict flag and its retune are seen
  task t_conflict;
    @(posedge clk_sys);
    u_host.pstrb <= 4'he;
    wr(12'h3a4, 32'h10);
    u_host.pstrb <= 4'hf;
    rdc("strb_off", 12'h3a4, 32'hef);
    wr(12'h3a4, 32'h10);
    rdc("conflict", 12'h3e0, 32'h6);
    chk("freq_c", {16'h0, 16'd2048}, {16'h0, fkhz});
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("ref_c", 12'h3a4, 32'h10);
    wr(12'h3e0, 32'h6);
    rdc("status1", 12'h3e0, 32'h0);
    $display("t_conflict done");
  endtask
  initial
  begin
    arst_n = 1'b0;
    chirq = 14'h0;
    clkp = 14'h3fff;
    txd = 14'h0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_freq;
    t_pattern;
    t_summary;
    t_irq;
    t_conflict;
    stop_test;
  end
endmodule // global_clock_and_irq_regs_tb
`default_nettype wire

// ===== rtl/global_clock_and_irq_regs.v
// Behaviour
// - Missing transmit clock sends ones or zeros
// - Four-bit code selects reference frequency
// - Top three select bits store, no function
// - Low summary holds channels 0 to 7
// - High summary holds channels 8 to 13
// - High summary top two bits read zero
// - Summary bit zero without new activity
// - Synthesizer retunes when the code changes value
`timescale 1ns/1ps
`default_nettype none
`include "global_clock_and_irq_regs.vh"

module global_clock_and_irq_regs (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [`DATA_W-1:0] pwdata,
  input wire [3:0] pstrb,
  output reg [`DATA_W-1:0] prdata,
  output reg pready,
  output reg pslverr,
  // Per-channel interrupt requests and transmit state
  input wire [`CHAN_N-1:0] channel_irq_in,
  input wire [`CHAN_N-1:0] transmit_line_clock_present,
  input wire [`CHAN_N-1:0] tx_data,
  // Line driver data and synthesizer control
  output reg [`CHAN_N-1:0] line_driver_outputs,
  output reg [`CHAN_N-1:0] all_ones_transmit,
  output reg [`FREQ_KHZ_W-1:0] synth_freq_khz,
  output reg synth_retune,
  // Interrupt
  output reg irq
);

  // Register state
  reg [`REG_W-1:0] reference_clock_select;
  reg [`IRQ_EV_W-1:0] irq_mask;
  reg [`CHAN_N-1:0] read_snapshot;
  reg [`FREQ_W-1:0] applied_code;
  wire [`CHAN_N-1:0] channel_irq_flag;
  wire [`IRQ_EV_W-1:0] irq_status;

  // Bus phases
  wire access = psel & penable;
  wire capture = access & ~pready;
  wire done = access & pready;
  wire wr_done = done & pwrite & pstrb[0];
  wire rd_done = done & ~pwrite;

  // Address decode
  wire hit_ref = paddr == `IDX_TO_ADDR(`REF_SEL_IDX);
  wire hit_lo = paddr == `IDX_TO_ADDR(`IRQ_SUM_LO_IDX);
  wire hit_hi = paddr == `IDX_TO_ADDR(`IRQ_SUM_HI_IDX);
  wire hit_st = paddr == `IDX_TO_ADDR(`IRQ_STATUS_IDX);
  wire hit_mk = paddr == `IDX_TO_ADDR(`IRQ_MASK_IDX);
  wire hit_any = hit_ref | hit_lo | hit_hi | hit_st | hit_mk;

  // Write data fields
  wire [`FREQ_W-1:0] wr_code = pwdata[`FREQ_MSB:`FREQ_LSB];
  wire wr_pat = pwdata[`TXPAT_BIT];
  wire code_changes = wr_code != reference_clock_select[`FREQ_MSB:`FREQ_LSB];
  wire pat_changes = wr_pat != reference_clock_select[`TXPAT_BIT];
  wire ref_write = wr_done & hit_ref;

  // Current selections
  wire [`FREQ_W-1:0] freq_code = reference_clock_select[`FREQ_MSB:`FREQ_LSB];
  wire missing_tx_clock_pattern_sel = reference_clock_select[`TXPAT_BIT];

  // Frequency decode; unlisted codes fall back to the reset frequency
  reg [`FREQ_KHZ_W-1:0] next_freq_khz;
  always @*
  begin
    case (freq_code)
      `CODE_2048: next_freq_khz = `KHZ_2048;
      `CODE_1544: next_freq_khz = `KHZ_1544;
      `CODE_4096: next_freq_khz = `KHZ_4096;
      `CODE_3088: next_freq_khz = `KHZ_3088;
      `CODE_8192: next_freq_khz = `KHZ_8192;
      `CODE_6176: next_freq_khz = `KHZ_6176;
      `CODE_16384: next_freq_khz = `KHZ_16384;
      `CODE_12352: next_freq_khz = `KHZ_12352;
      `CODE_2048_ALT: next_freq_khz = `KHZ_2048;
      `CODE_1544_ALT: next_freq_khz = `KHZ_1544;
      default: next_freq_khz = `KHZ_2048;
    endcase
  end

  // Read data mux; unmapped and reserved bits read zero
  reg [`DATA_W-1:0] next_rdata;
  always @*
  begin
    next_rdata = {`DATA_W{1'b0}};
    if (hit_ref)
      next_rdata[`REG_W-1:0] = reference_clock_select;
    else if (hit_lo)
      next_rdata[`CHAN_LO_N-1:0] = channel_irq_flag[`CHAN_LO_N-1:0];
    else if (hit_hi)
      next_rdata[`CHAN_HI_N-1:0] = channel_irq_flag[`CHAN_N-1:`CHAN_LO_N];
    else if (hit_st)
      next_rdata[`IRQ_EV_W-1:0] = irq_status;
    else if (hit_mk)
      next_rdata[`IRQ_EV_W-1:0] = irq_mask;
  end

  // Which summary bits the captured read will clear at completion
  reg [`CHAN_N-1:0] next_snapshot;
  always @*
  begin
    next_snapshot = {`CHAN_N{1'b0}};
    if (hit_lo)
      next_snapshot[`CHAN_LO_N-1:0] = channel_irq_flag[`CHAN_LO_N-1:0];
    else if (hit_hi)
      next_snapshot[`CHAN_N-1:`CHAN_LO_N] = channel_irq_flag[`CHAN_N-1:`CHAN_LO_N];
  end

  // APB answer: one wait state, data and pready from flops
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {`DATA_W{1'b0}};
      read_snapshot <= {`CHAN_N{1'b0}};
    end
    else
    begin
      pready <= capture;
      pslverr <= capture & ~hit_any;
      if (capture & ~pwrite)
      begin
        prdata <= next_rdata;
        read_snapshot <= next_snapshot;
      end
      else if (done)
        read_snapshot <= {`CHAN_N{1'b0}};
    end
  end

  // Clock select and mask registers, written at the completing edge
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reference_clock_select <= `REF_SEL_RESET;
      irq_mask <= `IRQ_EV_RESET;
    end
    else
    begin
      if (ref_write)
        reference_clock_select <= pwdata[`REG_W-1:0];
      if (wr_done & hit_mk)
        irq_mask <= pwdata[`IRQ_EV_W-1:0];
    end
  end

  // Summary flags clear only the bits the host actually saw
  sticky_flags #(
    .WIDTH(`CHAN_N)
  ) u_channel_flags (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .set(channel_irq_in),
    .clr(rd_done ? read_snapshot : {`CHAN_N{1'b0}}),
    .flags(channel_irq_flag)
  );

  // Block events: a pattern and code change in one write is flagged, since
  // the retune may disturb the same write; the write still takes effect
  wire [`IRQ_EV_W-1:0] ev_set;
  assign ev_set[`EV_CHAN_BIT] = |channel_irq_in;
  assign ev_set[`EV_RETUNE_BIT] = synth_retune;
  assign ev_set[`EV_CONFLICT_BIT] = ref_write & code_changes & pat_changes;

  // Interrupt status, write one to clear
  sticky_flags #(
    .WIDTH(`IRQ_EV_W)
  ) u_irq_status (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .set(ev_set),
    .clr((wr_done & hit_st) ? pwdata[`IRQ_EV_W-1:0] : `IRQ_EV_RESET),
    .flags(irq_status)
  );

  // Synthesizer target follows the code; a change pulses a retune
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      applied_code <= `CODE_2048;
      synth_freq_khz <= `KHZ_2048;
      synth_retune <= 1'b0;
    end
    else
    begin
      applied_code <= freq_code;
      synth_freq_khz <= next_freq_khz;
      synth_retune <= applied_code != freq_code;
    end
  end

  // Line outputs: pass data while the clock runs, else the chosen pattern
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_driver_outputs <= {`CHAN_N{1'b0}};
      all_ones_transmit <= {`CHAN_N{1'b0}};
    end
    else
    begin
      line_driver_outputs <= (tx_data & transmit_line_clock_present)
        | ({`CHAN_N{missing_tx_clock_pattern_sel}} & ~transmit_line_clock_present);
      all_ones_transmit <= {`CHAN_N{missing_tx_clock_pattern_sel}}
        & ~transmit_line_clock_present;
    end
  end

  // Level interrupt while any unmasked status bit is set
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

endmodule // global_clock_and_irq_regs

`default_nettype wire

// ===== rtl/global_clock_and_irq_regs.vh
`ifndef GLOBAL_CLOCK_AND_IRQ_REGS_VH
`define GLOBAL_CLOCK_AND_IRQ_REGS_VH

// Bus widths
`define ADDR_W 12
`define DATA_W 32
`define REG_W 8
`define CHAN_N 14
`define CHAN_LO_N 8
`define CHAN_HI_N 6

// Register indices; the byte address is four times the index
`define REF_SEL_IDX 8'he9
`define IRQ_SUM_LO_IDX 8'hea
`define IRQ_SUM_HI_IDX 8'heb
`define IRQ_STATUS_IDX 8'hf8
`define IRQ_MASK_IDX 8'hf9
`define IDX_TO_ADDR(i) {2'b00, i, 2'b00}

// Reference clock select fields
`define TXPAT_BIT 4
`define FREQ_MSB 3
`define FREQ_LSB 0
`define FREQ_W 4
`define REF_SEL_RESET 8'h00
`define IRQ_SUM_RESET 8'h00

// Frequency codes and synthesizer targets in kHz
`define FREQ_KHZ_W 16
`define CODE_2048 4'h0
`define CODE_1544 4'h1
`define CODE_4096 4'h8
`define CODE_3088 4'h9
`define CODE_8192 4'ha
`define CODE_6176 4'hb
`define CODE_16384 4'hc
`define CODE_12352 4'hd
`define CODE_2048_ALT 4'he
`define CODE_1544_ALT 4'hf
`define KHZ_2048 16'd2048
`define KHZ_1544 16'd1544
`define KHZ_4096 16'd4096
`define KHZ_3088 16'd3088
`define KHZ_8192 16'd8192
`define KHZ_6176 16'd6176
`define KHZ_16384 16'd16384
`define KHZ_12352 16'd12352

// Interrupt status layout
`define IRQ_EV_W 3
`define EV_CHAN_BIT 0
`define EV_RETUNE_BIT 1
`define EV_CONFLICT_BIT 2
`define IRQ_EV_RESET 3'h0

`endif

// ===== rtl/sticky_flags.v
`timescale 1ns/1ps
`default_nettype none

// Bank of sticky flags; a set in the same cycle as a clear wins
module sticky_flags #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Events and clears
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  // Flag state
  output reg [WIDTH-1:0] flags
);

  // Clear only what is not being set again, so no event is lost
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      flags <= {WIDTH{1'b0}};
    else
      flags <= (flags & ~clr) | set;
  end

endmodule // sticky_flags

`default_nettype wire
